// ===== rtl/ttg_defines.vh
// Purpose: constants for the two-level acquisition timebase generator
// Assumes: 10 MHz system clock
// Notes:   timebase inputs are sampled levels, not clocks
`ifndef TTG_DEFINES_VH
`define TTG_DEFINES_VH
`define TTG_SRC_W        3
`define TTG_CNT_W        16
`define TTG_CLK_PERIOD_NS 100
// minimum timebase pulse width and period, ns
`define TTG_MIN_PULSE_NS 12.5
`define TTG_MIN_PERIOD_NS 50.0
// reset values of the divide and group counts
`define TTG_RST_DIV      16'h0001
`define TTG_RST_GROUP    16'h0001
// external convert delay, in system clocks
`define TTG_EXT_DLY      2
`endif

// ===== rtl/ttg_level_sync.v
// Purpose: two flip-flop synchroniser with rising-edge detect
// Assumes: input is asynchronous to clk
// Notes:   first stage feeds only the second stage
`default_nettype none
module ttg_level_sync (
	input  wire clk,
	input  wire arst_n,
	input  wire ce,
	input  wire din,
	output reg  level,
	output reg  rise
);
	reg meta;
	reg sync;
	// stages, then edge detect on stable copy
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta  <= 1'b0;
			sync  <= 1'b0;
			level <= 1'b0;
			rise  <= 1'b0;
		end else if (ce) begin
			meta  <= din;
			sync  <= meta;
			level <= sync;
			rise  <= sync & ~level;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/ttg_timebase_gen.v
// Purpose: convert and sample level timebase generator for analog input timing
// Assumes: all bus and terminal inputs are asynchronous levels, sampled on CLK
// Notes:   both levels run from CLK and advance on edges of their own timebase
`default_nettype none
`include "ttg_defines.vh"
module ttg_timebase_gen #(
	parameter BUS_W = 8,
	parameter CNT_W = `TTG_CNT_W
) (
	input  wire                  CLK,
	input  wire                  ARST_N,
	input  wire                  CE,
	input  wire [BUS_W-1:0]      SIGNAL_BUS,
	input  wire [`TTG_SRC_W-1:0] CONV_SRC_SEL,
	input  wire [`TTG_SRC_W-1:0] SAMP_SRC_SEL,
	input  wire                  EXT_CONVERT_MODE,
	input  wire                  START_TRIG,
	input  wire [CNT_W-1:0]      CONV_DIV,
	input  wire [CNT_W-1:0]      PRESCALE_DIV,
	input  wire [CNT_W-1:0]      GROUP_SIZE,
	input  wire [CNT_W-1:0]      SAMP_DIV,
	output reg                   CONV_TIMEBASE,
	output reg                   SYNC_CONV_TIMEBASE,
	output reg                   SAMP_TIMEBASE,
	output reg                   SYNC_SAMP_TIMEBASE,
	output reg                   SAMPLE_CLOCK,
	output reg                   ADC_CONVERSION_STROBE,
	output reg                   CONV_RUNNING,
	output reg                   SAMP_RUNNING
);
	// bus selection before synchronising
	wire conv_raw;
	wire samp_raw;
	wire ext_mode;
	wire conv_lvl;
	wire samp_lvl;
	wire start_c_rise;
	wire start_s_rise;
	wire samp_tb_rise;
	wire samp_sync_rise;
	wire samp_pulse_lvl;
	wire samp_evt;
	reg  [`TTG_EXT_DLY-1:0] ext_dly;
	reg  conv_prev;
	reg  samp_prev;
	reg  trig_c_cap;
	reg  trig_s_cap;
	reg  start_c_seen;
	reg  start_s_seen;
	reg  samp_sync_prev;
	reg  samp_evt_q;
	reg  [CNT_W-1:0] div_cnt;
	reg  [CNT_W-1:0] pre_cnt;
	reg  [CNT_W-1:0] grp_cnt;
	reg  [CNT_W-1:0] samp_cnt;
	reg  grp_active;
	reg  samp_toggle;
	reg  conv_tb_q;
	wire conv_tb_rise;
	wire conv_sync_rise;

	assign conv_raw = SIGNAL_BUS[CONV_SRC_SEL];
	assign samp_raw = SIGNAL_BUS[SAMP_SRC_SEL];

	// pins pass three flops before use
	ttg_level_sync u_sync_conv (
		.clk    (CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.din    (conv_raw),
		.level  (conv_lvl),
		.rise   ()
	);
	ttg_level_sync u_sync_samp (
		.clk    (CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.din    (samp_raw),
		.level  (samp_lvl),
		.rise   ()
	);
	ttg_level_sync u_sync_mode (
		.clk    (CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.din    (EXT_CONVERT_MODE),
		.level  (ext_mode),
		.rise   ()
	);
	ttg_level_sync u_sync_start_c (
		.clk    (CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.din    (START_TRIG),
		.level  (),
		.rise   (start_c_rise)
	);
	ttg_level_sync u_sync_start_s (
		.clk    (CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.din    (START_TRIG),
		.level  (),
		.rise   (start_s_rise)
	);
	// sample pulse crosses as a toggle
	// both toggle edges are events, so the rise output is not used
	ttg_level_sync u_sync_samp_evt (
		.clk    (CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.din    (samp_toggle),
		.level  (samp_pulse_lvl),
		.rise   ()
	);

	// timebase outputs; ext mode delays the convert copy
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ext_dly            <= {`TTG_EXT_DLY{1'b0}};
			CONV_TIMEBASE      <= 1'b0;
			SYNC_CONV_TIMEBASE <= 1'b1;
			SAMP_TIMEBASE      <= 1'b0;
			SYNC_SAMP_TIMEBASE <= 1'b1;
		end else if (CE) begin
			ext_dly <= {ext_dly[`TTG_EXT_DLY-2:0], conv_lvl};
			if (ext_mode) begin
				SYNC_CONV_TIMEBASE <= conv_lvl;
				CONV_TIMEBASE      <= ext_dly[`TTG_EXT_DLY-1];
			end else begin
				SYNC_CONV_TIMEBASE <= ~conv_lvl;
				CONV_TIMEBASE      <= conv_lvl;
			end
			SAMP_TIMEBASE      <= samp_lvl;
			SYNC_SAMP_TIMEBASE <= ~samp_lvl;
		end
	end

	// edge detect on the generated timebases
	assign conv_tb_rise   = CONV_TIMEBASE & ~conv_tb_q;
	assign conv_sync_rise = SYNC_CONV_TIMEBASE & ~conv_prev;
	assign samp_tb_rise   = SAMP_TIMEBASE & ~samp_prev;
	assign samp_sync_rise = SYNC_SAMP_TIMEBASE & ~samp_sync_prev;
	// any change of the crossed toggle is one sample event
	assign samp_evt       = samp_pulse_lvl ^ samp_evt_q;

	// trigger capture on sync edge, used on the next active edge
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			conv_tb_q      <= 1'b0;
			conv_prev      <= 1'b1;
			samp_prev      <= 1'b0;
			samp_sync_prev <= 1'b1;
			samp_evt_q     <= 1'b0;
			start_c_seen   <= 1'b0;
			start_s_seen   <= 1'b0;
			trig_c_cap     <= 1'b0;
			trig_s_cap     <= 1'b0;
		end else if (CE) begin
			conv_tb_q      <= CONV_TIMEBASE;
			conv_prev      <= SYNC_CONV_TIMEBASE;
			samp_prev      <= SAMP_TIMEBASE;
			samp_sync_prev <= SYNC_SAMP_TIMEBASE;
			samp_evt_q     <= samp_pulse_lvl;
			// start edges are held until reset, for a sync edge to take them
			if (start_c_rise)
				start_c_seen <= 1'b1;
			if (start_s_rise)
				start_s_seen <= 1'b1;
			// capture on sync edge
			// sync rises ahead of the next convert rise in both modes
			if (conv_sync_rise && (start_c_seen || start_c_rise))
				trig_c_cap <= 1'b1;
			if (samp_sync_rise && (start_s_seen || start_s_rise))
				trig_s_cap <= 1'b1;
		end
	end

	// sample level: divider makes sample clocks
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			samp_cnt     <= `TTG_RST_DIV;
			SAMP_RUNNING <= 1'b0;
			SAMPLE_CLOCK <= 1'b0;
			samp_toggle  <= 1'b0;
		end else if (CE) begin
			SAMPLE_CLOCK <= 1'b0;
			if (samp_tb_rise && trig_s_cap)
				SAMP_RUNNING <= 1'b1;
			if (SAMP_RUNNING && samp_tb_rise) begin
				if (samp_cnt <= 1) begin
					samp_cnt     <= SAMP_DIV;
					SAMPLE_CLOCK <= 1'b1;
					samp_toggle  <= ~samp_toggle;
				end else begin
					samp_cnt <= samp_cnt - 1'b1;
				end
			end
		end
	end

	// convert level: group, prescale and divider counters
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_cnt               <= `TTG_RST_DIV;
			pre_cnt               <= `TTG_RST_DIV;
			grp_cnt               <= `TTG_RST_GROUP;
			grp_active            <= 1'b0;
			CONV_RUNNING          <= 1'b0;
			ADC_CONVERSION_STROBE <= 1'b0;
		end else if (CE) begin
			ADC_CONVERSION_STROBE <= 1'b0;
			if (conv_tb_rise && trig_c_cap)
				CONV_RUNNING <= 1'b1;
			if (CONV_RUNNING && samp_evt && !grp_active) begin
				grp_active <= 1'b1;
				grp_cnt    <= GROUP_SIZE;
				pre_cnt    <= PRESCALE_DIV;
				div_cnt    <= CONV_DIV;
			end else if (grp_active && conv_tb_rise) begin
				if (ext_mode) begin
					ADC_CONVERSION_STROBE <= 1'b1;
					if (grp_cnt <= 1)
						grp_active <= 1'b0;
					grp_cnt <= grp_cnt - 1'b1;
				end else if (pre_cnt > 1) begin
					pre_cnt <= pre_cnt - 1'b1;
				end else if (div_cnt > 1) begin
					div_cnt <= div_cnt - 1'b1;
				end else begin
					div_cnt               <= CONV_DIV;
					ADC_CONVERSION_STROBE <= 1'b1;
					if (grp_cnt <= 1)
						grp_active <= 1'b0;
					grp_cnt <= grp_cnt - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/ttg_timebase_checker.sv
// Purpose: port assertions for the timebase generator
// Assumes: CE held high, source selects static
// Notes:   copies are judged only once 8 clocks have settled
`default_nettype none
module ttg_timebase_checker #(
	parameter BUS_W = 8,
	parameter CNT_W = 16
) (
	input wire logic             CLK,
	input wire logic             ARST_N,
	input wire logic [BUS_W-1:0] SIGNAL_BUS,
	input wire logic [2:0]       CONV_SRC_SEL,
	input wire logic [2:0]       SAMP_SRC_SEL,
	input wire logic             EXT_CONVERT_MODE,
	input wire logic             CONV_TIMEBASE,
	input wire logic             SYNC_CONV_TIMEBASE,
	input wire logic             SAMP_TIMEBASE,
	input wire logic             SYNC_SAMP_TIMEBASE,
	input wire logic             SAMPLE_CLOCK,
	input wire logic             ADC_CONVERSION_STROBE,
	input wire logic             CONV_RUNNING,
	input wire logic             SAMP_RUNNING
);
	logic       cs;
	logic       ss;
	logic       mode_q;
	logic [3:0] settle;
	logic       ok;
	logic       ext;
	// sources as picked off the bus
	assign cs = SIGNAL_BUS[CONV_SRC_SEL];
	assign ss = SIGNAL_BUS[SAMP_SRC_SEL];
	assign ok = settle > 4'h7;
	assign ext = EXT_CONVERT_MODE;
	// restart on reset or mode change so past values never span them
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			settle <= 4'h0;
			mode_q <= 1'b0;
		end else begin
			mode_q <= ext;
			settle <= (ext != mode_q) ? 4'h0 : settle + {3'h0, settle != 4'hf};
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	sequence strobe_pulse;
		ADC_CONVERSION_STROBE ##1 !ADC_CONVERSION_STROBE;
	endsequence
	a_samp_tb_copy: assert property (ok |-> SAMP_TIMEBASE == $past(ss, 4))
		else $error("sample timebase not a copy");
	a_samp_sync_inv: assert property (SYNC_SAMP_TIMEBASE != SAMP_TIMEBASE)
		else $error("sample sync not inverse");
	a_conv_sync_div: assert property (ok && !ext |-> SYNC_CONV_TIMEBASE == !$past(cs, 4))
		else $error("divided sync not inverse");
	a_conv_sync_ext: assert property (ok && ext |-> SYNC_CONV_TIMEBASE == $past(cs, 4))
		else $error("external sync not raw");
	a_conv_tb_ext: assert property (ok && ext |-> CONV_TIMEBASE == $past(SYNC_CONV_TIMEBASE, 2))
		else $error("external timebase not delayed");
	a_samp_idle_gate: assert property (!SAMP_RUNNING |-> !SAMPLE_CLOCK)
		else $error("sample clock while idle");
	a_conv_idle_gate: assert property (!CONV_RUNNING |-> !ADC_CONVERSION_STROBE)
		else $error("strobe while idle");
	a_strobe_one_cycle: assert property (ADC_CONVERSION_STROBE |-> strobe_pulse)
		else $error("strobe longer than one cycle");
	// a level may only arm on a rising edge of its own timebase
	a_conv_arm_edge: assert property ($rose(CONV_RUNNING) |-> $past(CONV_TIMEBASE) && !$past(CONV_TIMEBASE, 2))
		else $error("convert level armed off its timebase edge");
	a_samp_arm_edge: assert property ($rose(SAMP_RUNNING) |-> $past(SAMP_TIMEBASE) && !$past(SAMP_TIMEBASE, 2))
		else $error("sample level armed off its timebase edge");
endmodule
`default_nettype wire

// ===== testbench/ttg_far_end.sv
// Purpose: terminals and timebases feeding the signal bus
// Assumes: sources slower than a quarter of CLK
// Notes:   irregular mode jitters the convert source
`default_nettype none
module ttg_far_end (
	input  wire logic       clk,
	input  wire logic [2:0] conv_sel,
	input  wire logic [2:0] samp_sel,
	input  wire logic       irregular,
	output var  logic [7:0] bus
);
	timeunit 1ns;
	timeprecision 100ps;
	int   seed = 32'h1af7;
	int   gap;
	logic conv = 1'b0;
	logic samp = 1'b0;
	// free sources with no phase tie to clk
	// half a ns off the grid, so no source edge lands on a CLK edge
	initial begin
		#0.5;
		forever begin
			gap = irregular ? 300 + {$random(seed)} % 400 : 330;
			#(gap) conv = ~conv;
		end
	end
	initial begin
		#0.5;
		forever #1130 samp = ~samp;
	end
	// unused lines toggle so a wrong select never matches
	always_comb begin
		bus = {8{clk}};
		bus[conv_sel] = conv;
		bus[samp_sel] = samp;
	end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: self-checking bench for the timebase generator
// Assumes: CE tied high, selects fixed within a run
// Notes:   runs: random divided, zero counts, external convert
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK = 1'b0;
	logic        ARST_N = 1'b0;
	logic        ext = 1'b0;
	logic        start = 1'b0;
	logic [2:0]  conv_sel = 3'h0;
	logic [2:0]  samp_sel = 3'h4;
	logic [15:0] cdiv = 16'h1;
	logic [15:0] pdiv = 16'h1;
	logic [15:0] grp = 16'h1;
	logic [15:0] sdiv = 16'h4;
	logic [7:0]  bus;
	wire logic   stb;
	wire logic   sclk;
	wire logic   stbase;
	wire logic   crun;
	wire logic   srun;
	int          seed = 32'h1af7;
	int          fails = 0;
	int          num_checks = 0;
	int          rises = 0;
	int          strobes = 0;
	int          n_samp = 0;
	logic        samp_q = 1'b0;
	logic        started = 1'b0;
	always #50 CLK = ~CLK;
	ttg_timebase_gen u_dut (.CLK(CLK), .ARST_N(ARST_N), .CE(1'b1), .SIGNAL_BUS(bus), .CONV_SRC_SEL(conv_sel),
		.SAMP_SRC_SEL(samp_sel), .EXT_CONVERT_MODE(ext), .START_TRIG(start), .CONV_DIV(cdiv), .PRESCALE_DIV(pdiv),
		.GROUP_SIZE(grp), .SAMP_DIV(sdiv), .CONV_TIMEBASE(), .SYNC_CONV_TIMEBASE(), .SAMP_TIMEBASE(stbase),
		.SYNC_SAMP_TIMEBASE(), .SAMPLE_CLOCK(sclk), .ADC_CONVERSION_STROBE(stb), .CONV_RUNNING(crun),
		.SAMP_RUNNING(srun));
	ttg_far_end u_far (.clk(CLK), .conv_sel(conv_sel), .samp_sel(samp_sel), .irregular(ext), .bus(bus));
	// counts of 0 or 1 both mean one
	function automatic logic [15:0] eff(input logic [15:0] v);
		return (v < 16'h2) ? 16'h1 : v;
	endfunction
	function automatic logic [15:0] rnd(input int n);
		return 16'(1 + {$random(seed)} % n);
	endfunction
	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	task conclude();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// settled view of each cycle, tallied per sample
	always @(posedge CLK) begin
		#1;
		if (!started) check("idle", 16'h0, {12'h0, sclk, stb, crun, srun});
		else begin
			rises += (stbase && !samp_q);
			strobes += stb;
			if (sclk === 1'b1) begin
				if (n_samp > 0) check("rises", eff(sdiv), rises[15:0]);
				if (n_samp > 0) check("strobes", eff(grp), strobes[15:0]);
				n_samp++;
				rises = 0;
				strobes = 0;
			end
		end
		samp_q = stbase;
	end
	// one run: settings, reset, idle span, then start
	task run(input logic e, input logic zero);
		#10;
		ARST_N = 1'b0;
		started = 1'b0;
		start = 1'b0;
		ext = e;
		cdiv = zero ? 16'h0 : rnd(3);
		pdiv = zero ? 16'h0 : rnd(2);
		grp = zero ? 16'h0 : rnd(3);
		sdiv = zero ? 16'h0 : 16'h3 + rnd(3);
		conv_sel = 3'(rnd(4)) - 3'h1;
		samp_sel = 3'(rnd(4)) + 3'h3;
		n_samp = 0;
		repeat (16) @(posedge CLK);
		#10 ARST_N = 1'b1;
		repeat (60) @(posedge CLK);
		#10 start = 1'b1;
		started = 1'b1;
		repeat (800) @(posedge CLK);
		check("samples", 16'h1, {15'h0, n_samp > 3});
	endtask
	initial begin
		run(1'b0, 1'b0);
		run(1'b0, 1'b1);
		run(1'b1, 1'b0);
		conclude();
	end
	// three runs take about 2630 clocks
	initial begin
		#400000;
		fails++;
		conclude();
	end
endmodule
bind ttg_timebase_gen ttg_timebase_checker #(.BUS_W(BUS_W), .CNT_W(CNT_W)) u_chk (.CLK, .ARST_N, .SIGNAL_BUS,
	.CONV_SRC_SEL, .SAMP_SRC_SEL, .EXT_CONVERT_MODE, .CONV_TIMEBASE, .SYNC_CONV_TIMEBASE, .SAMP_TIMEBASE,
	.SYNC_SAMP_TIMEBASE, .SAMPLE_CLOCK, .ADC_CONVERSION_STROBE, .CONV_RUNNING, .SAMP_RUNNING);
`default_nettype wire
